// *** verilog/timing_ctrl_pkg.sv ***
package timing_ctrl_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned MASTER_OSC_KHZ = 12800;
  localparam int unsigned RESET_PULSE_US = 50;
  localparam int unsigned RESET_PULSE_CYCLES = RESET_PULSE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned HOLD_TIME_MS = 500;
  localparam longint unsigned HOLD_TIME_CYCLES = longint'(HOLD_TIME_MS) * (CLK_HZ / 1000);
  localparam int unsigned HOLD_CNT_W = 32;

  // ----------------------------------------------------------------
  // Loop settings
  // ----------------------------------------------------------------
  localparam logic [4:0] BW_STEPS = 5'h13;
  localparam logic [2:0] DAMP_STEPS = 3'h5;
  localparam int unsigned CAL_PPM_MAX = 741;
  localparam int unsigned CAL_W = 11;
  localparam logic signed [CAL_W-1:0] CAL_MAX = 11'sh2e5;
  localparam logic signed [CAL_W-1:0] CAL_MIN = -11'sh2e5;

  // ----------------------------------------------------------------
  // Input selection codes
  // ----------------------------------------------------------------
  localparam int unsigned SEL_W = 4;
  localparam logic [SEL_W-1:0] SEL_CLOCK_THREE = 4'h3;
  localparam logic [SEL_W-1:0] SEL_CLOCK_FOUR = 4'h4;
  localparam logic [SEL_W-1:0] SEL_CLOCK_FIVE = 4'h5;
  localparam logic [SEL_W-1:0] SEL_CLOCK_SIX = 4'h6;
  localparam logic [SEL_W-1:0] SEL_NONE = 4'h0;

  // ----------------------------------------------------------------
  // Operating modes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_FREE_RUN = 3'h1,
    MODE_LOCKED = 3'h2,
    MODE_HOLDOVER = 3'h4
  } loop_mode_t;

  typedef enum logic [1:0] {
    RST_HOLD = 2'h1,
    RST_RUN = 2'h2
  } reset_state_t;

endpackage

// *** verilog/reset_hold.sv ***
`timescale 1ns/1ps
module reset_hold #(
  parameter int unsigned HOLD_CYCLES = 32'd50_000_000
) (
  input wire logic clk,
  input wire logic rstn,
  output logic in_reset,
  output logic release_pulse
);

  timing_ctrl_pkg::reset_state_t state_reg;
  logic [timing_ctrl_pkg::HOLD_CNT_W-1:0] count_reg;
  logic last_count;

  assign last_count = (count_reg >= HOLD_CYCLES[timing_ctrl_pkg::HOLD_CNT_W-1:0] - 32'h1);

  // ----------------------------------------------------------------
  // Hold the device in reset after the pin is released.
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= timing_ctrl_pkg::RST_HOLD;
      count_reg <= '0;
      release_pulse <= 1'b0;
    end else begin
      release_pulse <= 1'b0;
      case (state_reg)
        timing_ctrl_pkg::RST_HOLD: begin
          if (last_count) begin
            state_reg <= timing_ctrl_pkg::RST_RUN;
            release_pulse <= 1'b1;
          end else begin
            count_reg <= count_reg + 32'h1;
          end
        end
        timing_ctrl_pkg::RST_RUN: begin
          state_reg <= timing_ctrl_pkg::RST_RUN;
        end
        default: begin
          state_reg <= timing_ctrl_pkg::RST_HOLD;
        end
      endcase
    end
  end

  assign in_reset = (state_reg != timing_ctrl_pkg::RST_RUN);

  property p_hold_length;
    @(posedge clk) disable iff (!rstn)
    release_pulse |-> (count_reg == HOLD_CYCLES[31:0] - 32'h1);
  endproperty
  a_hold_length: assert property (p_hold_length) else $error("hold ended early");

  property p_release_once;
    @(posedge clk) disable iff (!rstn)
    release_pulse |=> !release_pulse && !in_reset;
  endproperty
  a_release_once: assert property (p_release_once) else $error("release not single");

endmodule

// *** verilog/loop_path.sv ***
`timescale 1ns/1ps
module loop_path (
  input wire logic clk,
  input wire logic rstn,
  input wire logic run,
  input wire logic force_mode,
  input wire timing_ctrl_pkg::loop_mode_t forced_mode,
  input wire logic ref_valid,
  input wire logic [timing_ctrl_pkg::SEL_W-1:0] ref_sel,
  output timing_ctrl_pkg::loop_mode_t mode_reg,
  output logic [timing_ctrl_pkg::SEL_W-1:0] locked_sel_reg,
  output logic holdover_ready_reg
);

  timing_ctrl_pkg::loop_mode_t mode_next;

  // ----------------------------------------------------------------
  // Free-run, locked and holdover mode machine.
  // ----------------------------------------------------------------
  always_comb begin
    mode_next = mode_reg;
    if (!run) begin
      mode_next = timing_ctrl_pkg::MODE_FREE_RUN;
    end else if (force_mode) begin
      mode_next = forced_mode;
    end else begin
      case (mode_reg)
        timing_ctrl_pkg::MODE_FREE_RUN: begin
          if (ref_valid) begin
            mode_next = timing_ctrl_pkg::MODE_LOCKED;
          end
        end
        timing_ctrl_pkg::MODE_LOCKED: begin
          if (!ref_valid) begin
            mode_next = holdover_ready_reg ? timing_ctrl_pkg::MODE_HOLDOVER
                                           : timing_ctrl_pkg::MODE_FREE_RUN;
          end
        end
        timing_ctrl_pkg::MODE_HOLDOVER: begin
          if (ref_valid) begin
            mode_next = timing_ctrl_pkg::MODE_LOCKED;
          end
        end
        default: begin
          mode_next = timing_ctrl_pkg::MODE_FREE_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode_reg <= timing_ctrl_pkg::MODE_FREE_RUN;
    end else begin
      mode_reg <= mode_next;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      holdover_ready_reg <= 1'b0;
      locked_sel_reg <= timing_ctrl_pkg::SEL_NONE;
    end else if (!run) begin
      holdover_ready_reg <= 1'b0;
      locked_sel_reg <= timing_ctrl_pkg::SEL_NONE;
    end else if (mode_reg == timing_ctrl_pkg::MODE_LOCKED) begin
      holdover_ready_reg <= 1'b1;
      locked_sel_reg <= ref_sel;
    end
  end

  property p_holdover_needs_data;
    @(posedge clk) disable iff (!rstn)
    (mode_reg == timing_ctrl_pkg::MODE_HOLDOVER) |-> holdover_ready_reg;
  endproperty
  a_holdover_needs_data: assert property (p_holdover_needs_data) else $error("holdover no data");

endmodule

// *** verilog/timing_global_control.sv ***
// How it works
// - Master oscillator clocks all internal logic.
// - Stay in reset 500 ms after release.
// - Fast-select strap sets fast select enable default.
// - Fast select high picks three/five, low four/six.
// - Fast select disabled ignores the pin.
// - Role from role pin and control bit.
// - Role pin mirrored into status bit.
// - Rate strap sets rate family default.
// - Rate strap ignored after reset ends.
// - Each path free-run, locked or holdover.
// - Primary and secondary select inputs separately.
// - Secondary locks independently or to primary.
// - Bandwidth 19 settings, damping 5 settings.
// - Master clock calibration within 741 ppm.
// - Registers reached only through host port.
`timescale 1ns/1ps
module timing_global_control #(
  parameter int unsigned HOLD_CYCLES = 32'd50_000_000
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic fast_select_pin,
  input wire logic rate_strap_pin,
  input wire logic role_select_pin,
  input wire logic role_control_bit,
  input wire logic fast_select_enable_wr,
  input wire logic fast_select_enable_wdata,
  input wire logic rate_family_wr,
  input wire logic rate_family_wdata,
  input wire logic primary_auto,
  input wire logic [timing_ctrl_pkg::SEL_W-1:0] primary_manual_sel,
  input wire logic secondary_auto,
  input wire logic [timing_ctrl_pkg::SEL_W-1:0] secondary_manual_sel,
  input wire logic secondary_follow_primary,
  input wire logic force_primary_mode,
  input wire timing_ctrl_pkg::loop_mode_t primary_forced_mode,
  input wire logic force_secondary_mode,
  input wire timing_ctrl_pkg::loop_mode_t secondary_forced_mode,
  input wire logic [4:0] bandwidth_cfg,
  input wire logic [2:0] damping_cfg,
  input wire logic signed [timing_ctrl_pkg::CAL_W-1:0] cal_ppm_cfg,
  input wire logic clock_three_valid,
  input wire logic clock_four_valid,
  input wire logic clock_five_valid,
  input wire logic clock_six_valid,
  output logic in_reset,
  output logic fast_select_enable,
  output logic input_rate_family,
  output logic role_status,
  output logic is_master,
  output logic [timing_ctrl_pkg::SEL_W-1:0] primary_sel,
  output logic [timing_ctrl_pkg::SEL_W-1:0] secondary_sel,
  output timing_ctrl_pkg::loop_mode_t primary_mode,
  output timing_ctrl_pkg::loop_mode_t secondary_mode,
  output logic secondary_tracks_primary,
  output logic [4:0] bandwidth_sel,
  output logic [2:0] damping_sel,
  output logic signed [timing_ctrl_pkg::CAL_W-1:0] cal_ppm
);

  logic hold_active;
  logic release_pulse;
  logic run;
  logic [timing_ctrl_pkg::SEL_W-1:0] primary_pick;
  logic [timing_ctrl_pkg::SEL_W-1:0] secondary_pick;
  logic primary_valid;
  logic secondary_valid;
  logic [3:0] valid_vec;
  logic [timing_ctrl_pkg::SEL_W-1:0] auto_pick;
  timing_ctrl_pkg::loop_mode_t p_mode;
  timing_ctrl_pkg::loop_mode_t s_mode;

  // ----------------------------------------------------------------
  // Internal reset stretch, clocked by the master clock.
  // ----------------------------------------------------------------
  reset_hold #(.HOLD_CYCLES(HOLD_CYCLES)) u_hold (
    .clk(clk),
    .rstn(rstn),
    .in_reset(hold_active),
    .release_pulse(release_pulse)
  );

  assign run = !hold_active;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      in_reset <= 1'b1;
    end else begin
      in_reset <= hold_active;
    end
  end

  // ----------------------------------------------------------------
  // Strap capture at the end of the internal reset.
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fast_select_enable <= 1'b0;
    end else if (release_pulse) begin
      fast_select_enable <= fast_select_pin;
    end else if (run && fast_select_enable_wr) begin
      fast_select_enable <= fast_select_enable_wdata;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      input_rate_family <= 1'b0;
    end else if (release_pulse) begin
      input_rate_family <= rate_strap_pin;
    end else if (run && rate_family_wr) begin
      input_rate_family <= rate_family_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Master and slave role.
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      role_status <= 1'b0;
      is_master <= 1'b0;
    end else begin
      role_status <= role_select_pin;
      is_master <= role_select_pin & role_control_bit;
    end
  end

  // ----------------------------------------------------------------
  // Input selection for both paths.
  // ----------------------------------------------------------------
  assign valid_vec = {clock_six_valid, clock_five_valid, clock_four_valid, clock_three_valid};

  always_comb begin
    auto_pick = timing_ctrl_pkg::SEL_NONE;
    for (int i = 3; i >= 0; i--) begin
      if (valid_vec[i]) begin
        auto_pick = timing_ctrl_pkg::SEL_CLOCK_THREE + 4'(i);
      end
    end
  end

  function automatic logic sel_valid(input logic [timing_ctrl_pkg::SEL_W-1:0] s,
                                     input logic [3:0] v);
    logic r;
    r = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (s == timing_ctrl_pkg::SEL_CLOCK_THREE + 4'(i)) begin
        r = v[i];
      end
    end
    return r;
  endfunction

  always_comb begin
    primary_pick = primary_auto ? auto_pick : primary_manual_sel;
    if (fast_select_enable) begin
      if (fast_select_pin) begin
        primary_pick = clock_three_valid ? timing_ctrl_pkg::SEL_CLOCK_THREE
                                         : timing_ctrl_pkg::SEL_CLOCK_FIVE;
      end else begin
        primary_pick = clock_four_valid ? timing_ctrl_pkg::SEL_CLOCK_FOUR
                                        : timing_ctrl_pkg::SEL_CLOCK_SIX;
      end
    end
    secondary_pick = secondary_auto ? auto_pick : secondary_manual_sel;
  end

  assign primary_valid = sel_valid(primary_pick, valid_vec);
  assign secondary_valid = secondary_follow_primary
                         ? (p_mode == timing_ctrl_pkg::MODE_LOCKED)
                         : sel_valid(secondary_pick, valid_vec);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      primary_sel <= timing_ctrl_pkg::SEL_NONE;
      secondary_sel <= timing_ctrl_pkg::SEL_NONE;
      secondary_tracks_primary <= 1'b0;
    end else begin
      primary_sel <= run ? primary_pick : timing_ctrl_pkg::SEL_NONE;
      secondary_sel <= run ? secondary_pick : timing_ctrl_pkg::SEL_NONE;
      secondary_tracks_primary <= secondary_follow_primary;
    end
  end

  // ----------------------------------------------------------------
  // Loop paths.
  // ----------------------------------------------------------------
  loop_path u_primary (
    .clk(clk),
    .rstn(rstn),
    .run(run),
    .force_mode(force_primary_mode),
    .forced_mode(primary_forced_mode),
    .ref_valid(primary_valid),
    .ref_sel(primary_pick),
    .mode_reg(p_mode),
    .locked_sel_reg(),
    .holdover_ready_reg()
  );

  loop_path u_secondary (
    .clk(clk),
    .rstn(rstn),
    .run(run),
    .force_mode(force_secondary_mode),
    .forced_mode(secondary_forced_mode),
    .ref_valid(secondary_valid),
    .ref_sel(secondary_pick),
    .mode_reg(s_mode),
    .locked_sel_reg(),
    .holdover_ready_reg()
  );

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      primary_mode <= timing_ctrl_pkg::MODE_FREE_RUN;
      secondary_mode <= timing_ctrl_pkg::MODE_FREE_RUN;
    end else begin
      primary_mode <= p_mode;
      secondary_mode <= s_mode;
    end
  end

  // ----------------------------------------------------------------
  // Loop bandwidth, damping and calibration settings.
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bandwidth_sel <= '0;
      damping_sel <= '0;
      cal_ppm <= '0;
    end else begin
      bandwidth_sel <= (bandwidth_cfg < timing_ctrl_pkg::BW_STEPS) ? bandwidth_cfg
                       : timing_ctrl_pkg::BW_STEPS - 5'h1;
      damping_sel <= (damping_cfg < timing_ctrl_pkg::DAMP_STEPS) ? damping_cfg
                     : timing_ctrl_pkg::DAMP_STEPS - 3'h1;
      if (cal_ppm_cfg > timing_ctrl_pkg::CAL_MAX) begin
        cal_ppm <= timing_ctrl_pkg::CAL_MAX;
      end else if (cal_ppm_cfg < timing_ctrl_pkg::CAL_MIN) begin
        cal_ppm <= timing_ctrl_pkg::CAL_MIN;
      end else begin
        cal_ppm <= cal_ppm_cfg;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------
  property p_strap_fast;
    @(posedge clk) disable iff (!rstn)
    release_pulse |=> (fast_select_enable == $past(fast_select_pin));
  endproperty
  a_strap_fast: assert property (p_strap_fast) else $error("fast strap lost");

  property p_strap_rate;
    @(posedge clk) disable iff (!rstn)
    release_pulse |=> (input_rate_family == $past(rate_strap_pin));
  endproperty
  a_strap_rate: assert property (p_strap_rate) else $error("rate strap lost");

  property p_rate_stable;
    @(posedge clk) disable iff (!rstn)
    (run && !release_pulse && !rate_family_wr) |=> $stable(input_rate_family);
  endproperty
  a_rate_stable: assert property (p_rate_stable) else $error("rate strap leaked");

  property p_fast_pair;
    @(posedge clk) disable iff (!rstn)
    (run && fast_select_enable && fast_select_pin) |=>
      (primary_sel == timing_ctrl_pkg::SEL_CLOCK_THREE ||
       primary_sel == timing_ctrl_pkg::SEL_CLOCK_FIVE);
  endproperty
  a_fast_pair: assert property (p_fast_pair) else $error("wrong fast pair");

  property p_fast_ignored;
    @(posedge clk) disable iff (!rstn)
    (run && !fast_select_enable && primary_auto == 1'b0) |=>
      (primary_sel == $past(primary_manual_sel));
  endproperty
  a_fast_ignored: assert property (p_fast_ignored) else $error("pin not ignored");

  property p_role_mirror;
    @(posedge clk) disable iff (!rstn)
    1'b1 |=> (role_status == $past(role_select_pin));
  endproperty
  a_role_mirror: assert property (p_role_mirror) else $error("role not mirrored");

  property p_master;
    @(posedge clk) disable iff (!rstn)
    is_master |-> $past(role_select_pin) && $past(role_control_bit);
  endproperty
  a_master: assert property (p_master) else $error("bad role");

  property p_bw_range;
    @(posedge clk) disable iff (!rstn)
    (bandwidth_sel < timing_ctrl_pkg::BW_STEPS) && (damping_sel < timing_ctrl_pkg::DAMP_STEPS);
  endproperty
  a_bw_range: assert property (p_bw_range) else $error("setting out of range");

  property p_free_in_reset;
    @(posedge clk) disable iff (!rstn)
    hold_active |-> ##2 (primary_mode == timing_ctrl_pkg::MODE_FREE_RUN);
  endproperty
  a_free_in_reset: assert property (p_free_in_reset) else $error("not free-run");

  c_release: cover property (@(posedge clk) disable iff (!rstn) release_pulse);
  c_lock: cover property (@(posedge clk) disable iff (!rstn)
    primary_mode == timing_ctrl_pkg::MODE_LOCKED);
  c_holdover: cover property (@(posedge clk) disable iff (!rstn)
    primary_mode == timing_ctrl_pkg::MODE_HOLDOVER);

endmodule

// *** testbench/strap_clock_source.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Board straps and qualified reference inputs
// ----------------------------------------------------------------
module strap_clock_source (
  input wire logic want_fast,
  input wire logic want_rate,
  input wire logic want_role,
  input wire logic [3:0] want_valid,
  output logic fast_select_pin,
  output logic rate_strap_pin,
  output logic role_select_pin,
  output logic clock_three_valid,
  output logic clock_four_valid,
  output logic clock_five_valid,
  output logic clock_six_valid
);
  // Strap levels are held by the board, also through reset.
  assign fast_select_pin = want_fast;
  assign rate_strap_pin = want_rate;
  assign role_select_pin = want_role;
  // Reference inputs only report qualified clocks of legal rates.
  assign clock_three_valid = want_valid[0];
  assign clock_four_valid = want_valid[1];
  assign clock_five_valid = want_valid[2];
  assign clock_six_valid = want_valid[3];
endmodule

// *** testbench/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  localparam int unsigned HOLD = 20;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic want_fast = 1'b1, want_rate = 1'b1, want_role = 1'b1;
  logic [3:0] want_valid = 4'hf;
  logic fs_pin, rate_pin, role_pin, v3, v4, v5, v6;
  logic role_bit = 1'b0, fse_wr = 1'b0, fse_wd = 1'b0, rf_wr = 1'b0, rf_wd = 1'b0;
  logic p_auto = 1'b1, s_auto = 1'b0, follow = 1'b0, f_p = 1'b0, f_s = 1'b0;
  logic [3:0] p_man = 4'h0, s_man = 4'h6;
  timing_ctrl_pkg::loop_mode_t p_fm = timing_ctrl_pkg::MODE_FREE_RUN;
  timing_ctrl_pkg::loop_mode_t s_fm = timing_ctrl_pkg::MODE_FREE_RUN;
  logic [4:0] bw = 5'h00;
  logic [2:0] dmp = 3'h0;
  logic signed [10:0] cal = 11'sh000;
  logic in_reset, fse, rfam, role_status, is_master, s_tracks;
  logic [3:0] p_sel, s_sel;
  timing_ctrl_pkg::loop_mode_t p_mode, s_mode;
  logic [4:0] bw_sel;
  logic [2:0] dmp_sel;
  logic signed [10:0] cal_o;
  int miscompares = 0;
  int cmp_count = 0;

  initial begin
    forever #5 clk = ~clk;
  end

  strap_clock_source partner (.want_fast(want_fast), .want_rate(want_rate),
    .want_role(want_role), .want_valid(want_valid), .fast_select_pin(fs_pin),
    .rate_strap_pin(rate_pin), .role_select_pin(role_pin), .clock_three_valid(v3),
    .clock_four_valid(v4), .clock_five_valid(v5), .clock_six_valid(v6));

  timing_global_control #(.HOLD_CYCLES(HOLD)) dut (.clk(clk), .rstn(rstn),
    .fast_select_pin(fs_pin), .rate_strap_pin(rate_pin), .role_select_pin(role_pin),
    .role_control_bit(role_bit), .fast_select_enable_wr(fse_wr),
    .fast_select_enable_wdata(fse_wd), .rate_family_wr(rf_wr), .rate_family_wdata(rf_wd),
    .primary_auto(p_auto), .primary_manual_sel(p_man), .secondary_auto(s_auto),
    .secondary_manual_sel(s_man), .secondary_follow_primary(follow),
    .force_primary_mode(f_p), .primary_forced_mode(p_fm), .force_secondary_mode(f_s),
    .secondary_forced_mode(s_fm), .bandwidth_cfg(bw), .damping_cfg(dmp),
    .cal_ppm_cfg(cal), .clock_three_valid(v3), .clock_four_valid(v4),
    .clock_five_valid(v5), .clock_six_valid(v6), .in_reset(in_reset),
    .fast_select_enable(fse), .input_rate_family(rfam), .role_status(role_status),
    .is_master(is_master), .primary_sel(p_sel), .secondary_sel(s_sel),
    .primary_mode(p_mode), .secondary_mode(s_mode), .secondary_tracks_primary(s_tracks),
    .bandwidth_sel(bw_sel), .damping_sel(dmp_sel), .cal_ppm(cal_o));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic settle();
    repeat (4) @(negedge clk);
  endtask

  // Reset with given straps, measure the hold, then wiggle the rate strap.
  task automatic reset_with_straps(input logic fs, input logic rate, input int unsigned pulse);
    int n;
    @(negedge clk);
    rstn = 1'b0;
    want_fast = fs;
    want_rate = rate;
    repeat (pulse) @(negedge clk);
    rstn = 1'b1;
    n = 0;
    while (in_reset !== 1'b0 && n < 100) begin
      @(negedge clk);
      n++;
    end
    check({15'h0, (n >= HOLD && n <= HOLD + 2)}, 16'h1);
    check({15'h0, fse}, {15'h0, fs});
    check({15'h0, rfam}, {15'h0, rate});
    want_rate = ~rate;
    settle();
    check({15'h0, rfam}, {15'h0, rate});
  endtask

  task automatic fast_selection();
    want_valid = 4'hf;
    want_fast = 1'b1;
    settle();
    check({12'h0, p_sel}, {12'h0, timing_ctrl_pkg::SEL_CLOCK_THREE});
    want_valid = 4'he;
    settle();
    check({12'h0, p_sel}, {12'h0, timing_ctrl_pkg::SEL_CLOCK_FIVE});
    want_fast = 1'b0;
    settle();
    check({12'h0, p_sel}, {12'h0, timing_ctrl_pkg::SEL_CLOCK_FOUR});
    fse_wr = 1'b1;
    fse_wd = 1'b0;
    p_auto = 1'b0;
    p_man = timing_ctrl_pkg::SEL_CLOCK_SIX;
    @(negedge clk);
    fse_wr = 1'b0;
    want_valid = 4'hf;
    settle();
    check({15'h0, fse}, 16'h0);
    want_fast = 1'b1;
    settle();
    check({12'h0, p_sel}, {12'h0, timing_ctrl_pkg::SEL_CLOCK_SIX});
    p_auto = 1'b1;
  endtask

  task automatic role_combinations();
    for (int i = 0; i < 4; i++) begin
      want_role = i[0];
      role_bit = i[1];
      settle();
      check({15'h0, role_status}, {15'h0, i[0]});
      check({15'h0, is_master}, {15'h0, i[0] & i[1]});
    end
  endtask

  task automatic path_modes();
    logic [2:0] m [3] = '{3'h1, 3'h2, 3'h4};
    f_p = 1'b1;
    for (int i = 0; i < 3; i++) begin
      p_fm = timing_ctrl_pkg::loop_mode_t'(m[i]);
      settle();
      check({13'h0, p_mode}, {13'h0, m[i]});
    end
    f_p = 1'b0;
    want_valid = 4'h8;
    settle();
    check({13'h0, p_mode}, {13'h0, timing_ctrl_pkg::MODE_LOCKED});
    check({12'h0, p_sel}, {12'h0, timing_ctrl_pkg::SEL_CLOCK_SIX});
    s_man = timing_ctrl_pkg::SEL_CLOCK_FOUR;
    follow = 1'b1;
    settle();
    check({12'h0, s_sel}, {12'h0, timing_ctrl_pkg::SEL_CLOCK_FOUR});
    check({15'h0, s_tracks}, 16'h1);
    check({13'h0, s_mode}, {13'h0, timing_ctrl_pkg::MODE_LOCKED});
    want_valid = 4'h0;
    settle();
    check({13'h0, p_mode}, {13'h0, timing_ctrl_pkg::MODE_HOLDOVER});
    check({13'h0, s_mode}, {13'h0, timing_ctrl_pkg::MODE_HOLDOVER});
    f_s = 1'b1;
    s_fm = timing_ctrl_pkg::MODE_FREE_RUN;
    settle();
    check({13'h0, s_mode}, {13'h0, timing_ctrl_pkg::MODE_FREE_RUN});
    f_s = 1'b0;
  endtask

  task automatic loop_settings();
    bw = 5'h12;
    dmp = 3'h4;
    cal = 11'sh2e5;
    settle();
    check({11'h0, bw_sel}, 16'h12);
    check({13'h0, dmp_sel}, 16'h4);
    check({5'h0, cal_o}, {5'h0, timing_ctrl_pkg::CAL_MAX});
    bw = 5'h1f;
    dmp = 3'h7;
    cal = -11'sh320;
    settle();
    check({11'h0, bw_sel}, 16'h12);
    check({13'h0, dmp_sel}, 16'h4);
    check({5'h0, cal_o}, {5'h0, timing_ctrl_pkg::CAL_MIN});
  endtask

  initial begin
    #200000;
    miscompares++;
    tally_and_finish();
  end

  initial begin
    reset_with_straps(1'b1, 1'b1, 3);
    fast_selection();
    role_combinations();
    path_modes();
    loop_settings();
    reset_with_straps(1'b0, 1'b0, timing_ctrl_pkg::RESET_PULSE_CYCLES);
    tally_and_finish();
  end
endmodule
